/* File: esr_pkg.sv */
// Function
// - Port frame counter stops while suspended; global counter keeps running, so they drift.
// - Counters time 125 us micro-frames; only the frame index is readable.
// - Setting run/stop from halted realigns global and per-port frame counters.
// - Resume exit enters high-speed without checking line state; late PHY can fault.
// - Fault only on high-speed ports; full-speed companion ports unaffected.
package esr_pkg;

  // Timing
  localparam int unsigned CLK_PERIOD_NS  = 20;
  localparam int unsigned MF_TIME_NS     = 125000;
  localparam int unsigned MF_CYCLES      = MF_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned FRINDEX_W      = 14;
  localparam int unsigned NUM_PORTS      = 2;

  // Register byte offsets
  localparam logic [7:0] REG_CMD        = 8'h00;
  localparam logic [7:0] REG_STS        = 8'h04;
  localparam logic [7:0] REG_INT_STS    = 8'h08;
  localparam logic [7:0] REG_INT_MASK   = 8'h0c;
  localparam logic [7:0] REG_FRINDEX    = 8'h10;
  localparam logic [7:0] REG_PORTSC0    = 8'h20;

  // Field positions
  localparam int unsigned CMD_RUN_BIT     = 0;
  localparam int unsigned STS_HALTED_BIT  = 0;
  localparam int unsigned INT_WAKE_BIT    = 0;
  localparam int unsigned INT_FAULT_BIT   = 1;
  localparam int unsigned INT_HALT_BIT    = 2;
  localparam int unsigned INT_W           = 3;
  localparam int unsigned PSC_SUSP_BIT    = 0;
  localparam int unsigned PSC_FPR_BIT     = 1;
  localparam int unsigned PSC_COMP_BIT    = 2;
  localparam int unsigned PSC_HSACK_BIT   = 3;

  // Reset values
  localparam logic             CMD_RUN_RST  = 1'b0;
  localparam logic [INT_W-1:0] INT_MASK_RST = 3'h0;

  // Controller run state, one-hot
  typedef enum logic [2:0] {
    ESR_HALTED   = 3'h1,
    ESR_RUNNING  = 3'h2,
    ESR_STOPPING = 3'h4
  } esr_run_t;

endpackage

/* File: esr_port.sv */
`timescale 1ns/10ps
module esr_port
  import esr_pkg::*;
#(
  parameter int unsigned MF_CYC = MF_CYCLES
) (
  input  wire logic                       clk_sys,
  input  wire logic                       sys_rst,
  input  wire logic                       clk_en,
  input  wire logic                       running,
  input  wire logic                       restart,
  input  wire logic                       wr_en,
  input  wire logic                       wr_susp,
  input  wire logic                       wr_fpr,
  input  wire logic                       wr_comp,
  input  wire logic                       wake_req,
  input  wire logic                       phy_hs_ack,
  output logic                            suspended,
  output logic                            force_resume,
  output logic                            companion,
  output logic                            hs_mode,
  output logic                            sof_pulse,
  output logic                            wake_event,
  output logic                            fault_event
);

  localparam int unsigned CW = $clog2(MF_CYC);
  localparam logic [CW-1:0] CNT_LAST = CW'(MF_CYC - 1);

  logic [CW-1:0] per_port_frame_counter;
  logic          wrap;

  assign wrap = (per_port_frame_counter == CNT_LAST);

  // Local count freezes during suspend, zeroed on restart
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      per_port_frame_counter <= '0;
    end else if (clk_en) begin
      if (restart) begin
        per_port_frame_counter <= '0;
      end else if (running && !suspended) begin
        per_port_frame_counter <= wrap ? '0 : per_port_frame_counter + 1'b1;
      end
    end
  end

  // Suspend, resume drive and owner state
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      suspended    <= 1'b0;
      force_resume <= 1'b0;
      companion    <= 1'b0;
      wake_event   <= 1'b0;
    end else if (clk_en) begin
      wake_event <= 1'b0;
      if (wr_en) begin
        companion <= wr_comp;
        if (wr_susp) begin
          suspended <= 1'b1;
        end
        if (wr_fpr) begin
          force_resume <= 1'b1;
        end else if (force_resume) begin
          // Exit ends at once; no wait for high-speed idle
          force_resume <= 1'b0;
          suspended    <= 1'b0;
        end
      end else if (suspended && !force_resume && wake_req && !companion) begin
        force_resume <= 1'b1;
        wake_event   <= 1'b1;
      end
    end
  end

  // High-speed request and SOF; a late PHY ack during SOF is the fault
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      hs_mode     <= 1'b0;
      sof_pulse   <= 1'b0;
      fault_event <= 1'b0;
    end else if (clk_en) begin
      hs_mode     <= !suspended && !force_resume && !companion;
      sof_pulse   <= running && wrap && hs_mode;
      fault_event <= running && wrap && hs_mode && !phy_hs_ack;
    end
  end

endmodule // esr_port

/* File: esr_top.sv */
`timescale 1ns/10ps
module esr_top
  import esr_pkg::*;
#(
  parameter int unsigned MF_CYC = MF_CYCLES,
  parameter int unsigned NPORT  = NUM_PORTS
) (
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire logic              clk_en,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  output logic                   irq,
  input  wire logic [NPORT-1:0]  wake_req,
  input  wire logic [NPORT-1:0]  phy_hs_ack,
  output logic      [NPORT-1:0]  port_suspended,
  output logic      [NPORT-1:0]  port_resume_drive,
  output logic      [NPORT-1:0]  port_hs_mode,
  output logic      [NPORT-1:0]  port_sof
);

  localparam int unsigned CW = $clog2(MF_CYC);
  localparam logic [CW-1:0] CNT_LAST = CW'(MF_CYC - 1);

  // Refuse shapes the decode cannot serve
  generate
    if (MF_CYC < 2) begin : g_bad_mf
      $error("esr_top: MF_CYC must be at least 2");
    end
    if (NPORT < 1 || NPORT > 8) begin : g_bad_np
      $error("esr_top: NPORT must be 1 to 8");
    end
  endgenerate

  esr_run_t              run_state;
  esr_run_t              next_run_state;
  logic                  run_stop;
  logic                  running;
  logic                  restart;
  logic [CW-1:0]         global_frame_counter;
  logic                  gwrap;
  logic [FRINDEX_W-1:0]  micro_frame_index;
  logic [INT_W-1:0]      int_sts;
  logic [INT_W-1:0]      int_mask;
  logic [INT_W-1:0]      int_set;
  logic [INT_W-1:0]      int_clr;
  logic                  halt_event;
  logic [NPORT-1:0]      wake_ev;
  logic [NPORT-1:0]      fault_ev;
  logic [NPORT-1:0]      comp;
  logic [NPORT-1:0]      port_wr;
  logic                  req;
  logic                  wr_ok;
  logic [31:0]           rd_mux;

  assign running = (run_state == ESR_RUNNING) || (run_state == ESR_STOPPING);
  assign gwrap   = (global_frame_counter == CNT_LAST);
  assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_ok   = req && wb_we_i && wb_sel_i[0];

  // Stop completes only at a micro-frame end, then halted shows
  always_comb begin
    next_run_state = run_state;
    case (run_state)
      ESR_HALTED: begin
        if (run_stop) begin
          next_run_state = ESR_RUNNING;
        end
      end
      ESR_RUNNING: begin
        if (!run_stop) begin
          next_run_state = ESR_STOPPING;
        end
      end
      ESR_STOPPING: begin
        if (run_stop) begin
          next_run_state = ESR_RUNNING;
        end else if (gwrap) begin
          next_run_state = ESR_HALTED;
        end
      end
      default: begin
        next_run_state = ESR_HALTED;
      end
    endcase
  end

  // Run state register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      run_state <= ESR_HALTED;
    end else if (clk_en) begin
      run_state <= next_run_state;
    end
  end

  // Leaving halted zeroes the global and per-port frame counters at once
  assign restart    = (run_state == ESR_HALTED) && run_stop;
  assign halt_event = (run_state == ESR_STOPPING) && !run_stop && gwrap;

  // Global count never pauses for suspend, only for halt
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      global_frame_counter <= '0;
      micro_frame_index    <= '0;
    end else if (clk_en) begin
      if (restart) begin
        global_frame_counter <= '0;
      end else if (running) begin
        global_frame_counter <= gwrap ? '0 : global_frame_counter + 1'b1;
        if (gwrap) begin
          micro_frame_index <= micro_frame_index + 1'b1;
        end
      end
    end
  end

  // Per-port sequencers
  genvar gi;
  generate
    for (gi = 0; gi < NPORT; gi++) begin : g_port
      assign port_wr[gi] = wr_ok && (wb_adr_i == REG_PORTSC0 + 8'(4 * gi));
      esr_port #(
        .MF_CYC (MF_CYC)
      ) u_port (
        .clk_sys      (clk_sys),
        .sys_rst      (sys_rst),
        .clk_en       (clk_en),
        .running      (running),
        .restart      (restart),
        .wr_en        (port_wr[gi]),
        .wr_susp      (wb_dat_i[PSC_SUSP_BIT]),
        .wr_fpr       (wb_dat_i[PSC_FPR_BIT]),
        .wr_comp      (wb_dat_i[PSC_COMP_BIT]),
        .wake_req     (wake_req[gi]),
        .phy_hs_ack   (phy_hs_ack[gi]),
        .suspended    (port_suspended[gi]),
        .force_resume (port_resume_drive[gi]),
        .companion    (comp[gi]),
        .hs_mode      (port_hs_mode[gi]),
        .sof_pulse    (port_sof[gi]),
        .wake_event   (wake_ev[gi]),
        .fault_event  (fault_ev[gi])
      );
    end
  endgenerate

  // Command register write
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      run_stop <= CMD_RUN_RST;
    end else if (clk_en) begin
      if (wr_ok && wb_adr_i == REG_CMD) begin
        run_stop <= wb_dat_i[CMD_RUN_BIT];
      end
    end
  end

  // Interrupt mask write
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      int_mask <= INT_MASK_RST;
    end else if (clk_en) begin
      if (wr_ok && wb_adr_i == REG_INT_MASK) begin
        int_mask <= wb_dat_i[INT_W-1:0];
      end
    end
  end

  // Sticky events; a set in the clearing read's cycle survives
  always_comb begin
    int_set                = '0;
    int_set[INT_WAKE_BIT]  = |wake_ev;
    int_set[INT_FAULT_BIT] = |fault_ev;
    int_set[INT_HALT_BIT]  = halt_event;
    int_clr = (req && !wb_we_i && wb_adr_i == REG_INT_STS) ? {INT_W{1'b1}} : '0;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      int_sts <= '0;
    end else if (clk_en) begin
      int_sts <= (int_sts & ~int_clr) | int_set;
    end
  end

  // Level interrupt, registered
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(((int_sts & ~int_clr) | int_set) & int_mask);
    end
  end

  // Read decode; unmapped offsets read zero
  always_comb begin
    rd_mux = 32'h0;
    if (wb_adr_i == REG_CMD) begin
      rd_mux[CMD_RUN_BIT] = run_stop;
    end else if (wb_adr_i == REG_STS) begin
      rd_mux[STS_HALTED_BIT] = (run_state == ESR_HALTED);
    end else if (wb_adr_i == REG_INT_STS) begin
      rd_mux[INT_W-1:0] = int_sts;
    end else if (wb_adr_i == REG_INT_MASK) begin
      rd_mux[INT_W-1:0] = int_mask;
    end else if (wb_adr_i == REG_FRINDEX) begin
      rd_mux[FRINDEX_W-1:0] = micro_frame_index;
    end else begin
      for (int i = 0; i < NPORT; i++) begin
        if (wb_adr_i == REG_PORTSC0 + 8'(4 * i)) begin
          rd_mux[PSC_SUSP_BIT]  = port_suspended[i];
          rd_mux[PSC_FPR_BIT]   = port_resume_drive[i];
          rd_mux[PSC_COMP_BIT]  = comp[i];
          rd_mux[PSC_HSACK_BIT] = phy_hs_ack[i];
        end
      end
    end
  end

  // One-wait-state answer; ack drops the cycle after
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else if (clk_en) begin
      wb_ack_o <= req;
      if (req && !wb_we_i) begin
        wb_dat_o <= rd_mux;
      end
    end
  end

endmodule // esr_top

/* File: esr_sva.sv */
`timescale 1ns/10ps
module esr_sva
  import esr_pkg::*;
#(
  parameter int unsigned MF_CYC = MF_CYCLES,
  parameter int unsigned NPORT  = NUM_PORTS
) (
  input wire logic             clk_sys,
  input wire logic             sys_rst,
  input wire logic             clk_en,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [7:0]       wb_adr_i,
  input wire logic [3:0]       wb_sel_i,
  input wire logic [31:0]      wb_dat_i,
  input wire logic             wb_ack_o,
  input wire logic [NPORT-1:0] wake_req,
  input wire logic [NPORT-1:0] phy_hs_ack,
  input wire logic [NPORT-1:0] port_suspended,
  input wire logic [NPORT-1:0] port_resume_drive,
  input wire logic [NPORT-1:0] port_hs_mode,
  input wire logic [NPORT-1:0] port_sof
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Request taken at this edge; a taken write to port 0 control
  logic take;
  logic wr0;
  assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o & clk_en;
  assign wr0  = take & wb_we_i & wb_sel_i[0] & (wb_adr_i == REG_PORTSC0);

  a_ack_next: assert property (take |=> wb_ack_o)
    else $error("no ack one cycle after request");
  a_ack_single: assert property (wb_ack_o && clk_en |=> !wb_ack_o)
    else $error("ack held past one cycle");
  a_sof_susp: assert property (port_sof[0] |-> !$past(port_suspended[0], 2))
    else $error("frame pulse from a suspended port");
  a_sof_gap: assert property (port_sof[0] && clk_en |=> !port_sof[0] [*2])
    else $error("frame pulses too close");
  a_wake_drive: assert property (wake_req[0] && port_suspended[0] && !port_resume_drive[0] && !wr0 && clk_en
    |=> port_resume_drive[0]) else $error("remote wake not answered");
  a_resume_exit: assert property (wr0 && port_resume_drive[0] && !wb_dat_i[1]
    |=> !port_resume_drive[0] && !port_suspended[0]) else $error("resume exit incomplete");
  a_suspend_set: assert property (wr0 && wb_dat_i[0] && (wb_dat_i[1] || !port_resume_drive[0])
    |=> port_suspended[0]) else $error("suspend write lost");
  a_hs_after_exit: assert property ($fell(port_resume_drive[0]) |-> ##[0:1] port_hs_mode[0])
    else $error("high-speed not entered after resume");

  // Main scenarios reached
  cover property (wr0 && port_resume_drive[0] && !wb_dat_i[1]);
  cover property (port_sof[0] && !phy_hs_ack[0]);
  cover property (wake_req[0] && port_suspended[0]);
endmodule // esr_sva

bind esr_top esr_sva #(.MF_CYC(MF_CYC), .NPORT(NPORT)) i_esr_sva (.clk_sys, .sys_rst, .clk_en, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .wake_req, .phy_hs_ack, .port_suspended,
  .port_resume_drive, .port_hs_mode, .port_sof);

/* File: esr_phy_model.sv */
`timescale 1ns/10ps
module esr_phy_model #(
  parameter int unsigned NPORT = 2
) (
  input  wire logic [0:0]       clk_sys,
  input  wire logic             sys_rst,
  input  wire logic [NPORT-1:0] port_suspended,
  input  wire logic [NPORT-1:0] port_resume_drive,
  input  wire logic [NPORT-1:0] wake_cmd,
  input  wire logic [15:0]      ack_delay,
  output logic      [NPORT-1:0] wake_req,
  output logic      [NPORT-1:0] phy_hs_ack
);
  logic [15:0] cnt [NPORT];

  // Idle indication comes ack_delay+1 cycles after resume ends; slow PHY exposes the exit hazard
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wake_req   <= '0;
      phy_hs_ack <= '0;
      for (int i = 0; i < NPORT; i++) cnt[i] <= 16'h0;
    end else begin
      for (int i = 0; i < NPORT; i++) begin
        if (port_suspended[i] || port_resume_drive[i]) begin
          phy_hs_ack[i] <= 1'h0;
          cnt[i]        <= 16'h0;
        end else if (cnt[i] >= ack_delay) begin
          phy_hs_ack[i] <= 1'h1;
        end else begin
          cnt[i] <= cnt[i] + 16'h1;
        end
        // Wake held until the host takes over resume signalling
        wake_req[i] <= wake_cmd[i] & port_suspended[i] & ~port_resume_drive[i];
      end
    end
  end
endmodule // esr_phy_model

/* File: ehci_port_suspend_resume_sequencing_tb_top.sv */
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module ehci_port_suspend_resume_sequencing_tb_top;
  import esr_pkg::*;
  localparam int unsigned MF   = 16;
  localparam int unsigned HOLD = 3 * MF; // Scaled stand-in for the 20 ms resume hold
  typedef struct packed {logic we; logic [7:0] a; logic [31:0] d; logic [31:0] e;} esr_row_t;
  logic        clk_sys = 1'h0;
  logic        sys_rst, clk_en, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, f0;
  logic [1:0]  wake_req, phy_hs_ack, port_suspended, port_resume_drive, port_hs_mode, port_sof, wake_cmd;
  logic [15:0] ack_dly;
  int          err_count, samples_checked, sof_n, cyc_n;
  esr_row_t    rows [13];

  esr_top #(.MF_CYC(MF)) i_esr_top (.clk_sys, .sys_rst, .clk_en, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq, .wake_req, .phy_hs_ack, .port_suspended,
    .port_resume_drive, .port_hs_mode, .port_sof);
  esr_phy_model i_esr_phy_model (.clk_sys, .sys_rst, .port_suspended, .port_resume_drive, .wake_cmd,
    .ack_delay(ack_dly), .wake_req, .phy_hs_ack);

  // Clock, frame pulse count and hang guard
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (port_sof[0] === 1'h1) sof_n++;
    cyc_n++;
    if (cyc_n == 5000) begin
      err_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Classic single cycle; held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
    do @(posedge clk_sys); while (wb_ack_o !== 1'h1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
  endtask

  // Poll until the frame index steps, so the next write lands at a frame start
  task automatic align(output logic [31:0] v);
    logic [31:0] s;
    wb(1'h0, REG_FRINDEX, 32'h0, s);
    do wb(1'h0, REG_FRINDEX, 32'h0, v); while (v === s);
  endtask

  // Host resume with aligned writes; d is PHY idle latency
  task automatic m1(input logic [15:0] d, input logic flt);
    logic [31:0] a, b, q;
    ack_dly <= d;
    align(a);
    wb(1'h1, REG_PORTSC0, 32'h1, q);
    sof_n = 0;
    repeat (HOLD) @(posedge clk_sys);
    `CHK("sof_susp", 0, sof_n)
    align(b);
    `CHK("frindex_runs", 1'h1, b > a)
    wb(1'h1, REG_PORTSC0, 32'h3, q);
    `CHK("fpr_set", 2'h3, {port_suspended[0], port_resume_drive[0]})
    repeat (HOLD) @(posedge clk_sys);
    align(b);
    wb(1'h1, REG_PORTSC0, 32'h0, q);
    `CHK("exit", 2'h0, {port_suspended[0], port_resume_drive[0]})
    repeat (4 * MF) @(posedge clk_sys);
    `CHK("sof_count", 1'h1, sof_n >= 3)
    `CHK("irq_masked", 1'h0, irq)
    wb(1'h0, REG_INT_STS, 32'h0, q);
    `CHK("fault", flt, q[INT_FAULT_BIT])
  endtask

  initial begin
    logic [31:0] q;
    int n;
    {sys_rst, clk_en, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = {2'h3, 47'h0f00000000};
    wake_cmd = 2'h0;
    ack_dly = 16'h2;
    rows = '{'{1'h0, REG_CMD, 32'h0, 32'h0}, '{1'h0, REG_STS, 32'h0, 32'h1}, '{1'h0, REG_INT_MASK, 32'h0, 32'h0},
      '{1'h0, REG_INT_STS, 32'h0, 32'h0}, '{1'h0, 8'h40, 32'h0, 32'h0}, '{1'h1, 8'h40, 32'hff, 32'h0},
      '{1'h0, 8'h40, 32'h0, 32'h0}, '{1'h1, REG_INT_MASK, 32'h7, 32'h0}, '{1'h0, REG_INT_MASK, 32'h0, 32'h7},
      '{1'h1, REG_INT_MASK, 32'h0, 32'h0}, '{1'h1, REG_FRINDEX, 32'h5, 32'h0},
      '{1'h0, REG_FRINDEX, 32'h0, 32'h0}, '{1'h0, REG_PORTSC0, 32'h0, 32'h8}};
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'h0;
    foreach (rows[i]) begin
      wb(rows[i].we, rows[i].a, rows[i].d, q);
      if (!rows[i].we) `CHK("reg_row", rows[i].e, q)
    end
    wb(1'h1, REG_CMD, 32'h1, q);
    align(f0);
    repeat (4 * MF) @(posedge clk_sys);
    wb(1'h0, REG_FRINDEX, 32'h0, q);
    `CHK("frindex_step", f0 + 32'h4, q)
    m1(16'h2, 1'h0);
    m1(16'h20, 1'h1);
    // Full-speed owned port ignores wake
    wb(1'h1, REG_PORTSC0 + 8'h4, 32'h5, q);
    wake_cmd <= 2'h2;
    repeat (8) @(posedge clk_sys);
    `CHK("comp_wake", 1'h0, port_resume_drive[1])
    wb(1'h1, REG_INT_MASK, 32'h1, q);
    wb(1'h1, REG_PORTSC0, 32'h1, q);
    wake_cmd <= 2'h1;
    while (port_resume_drive[0] !== 1'h1) @(posedge clk_sys);
    wake_cmd <= 2'h0;
    repeat (3) @(posedge clk_sys);
    `CHK("irq_wake", 1'h1, irq)
    wb(1'h0, REG_INT_STS, 32'h0, q);
    `CHK("wake_bit", 1'h1, q[INT_WAKE_BIT])
    repeat (2) @(posedge clk_sys);
    `CHK("irq_clr", 1'h0, irq)
    repeat (HOLD) @(posedge clk_sys);
    `CHK("m2_one_hs", 1'h0, port_hs_mode[1])
    wb(1'h1, REG_CMD, 32'h0, q);
    do wb(1'h0, REG_STS, 32'h0, q); while (q[STS_HALTED_BIT] !== 1'h1);
    wb(1'h0, REG_INT_STS, 32'h0, q);
    `CHK("halt_bit", 1'h1, q[INT_HALT_BIT])
    wb(1'h1, REG_PORTSC0, 32'h0, q);
    `CHK("m2_exit", 2'h0, {port_suspended[0], port_resume_drive[0]})
    wb(1'h1, REG_CMD, 32'h1, q);
    n = 0;
    while (port_sof[0] !== 1'h1) begin
      @(posedge clk_sys);
      n++;
    end
    `CHK("realign", 1'h1, n >= MF - 3 && n <= MF + 2)
    // Second reset in mid-run
    sys_rst <= 1'h1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'h0;
    wb(1'h0, REG_STS, 32'h0, q);
    `CHK("rst_halted", 32'h1, q)
    `CHK("rst_hs", 2'h3, port_hs_mode)
    stop_test();
  end
endmodule // ehci_port_suspend_resume_sequencing_tb_top
